/* rtl/swp_pkg.sv */
// Package with constants for the sector write-protection block.
package swp_pkg;
    localparam int UNIT_W = 10;
    localparam int N_UNITS = 542;
    localparam logic [15:0] MODE_RST = 16'hffff;
    localparam int MODE_SOLID_POS = 1;
    localparam int MODE_PASS_POS = 2;
    localparam int LOCK_POS = 0;
    localparam logic [7:0] BYTE_SET = 8'hff;
    localparam logic [7:0] BYTE_CLR = 8'h00;
    localparam logic [6:0] LOCK_UPPER = 7'h00;
    localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] CMD_MODE_WR = 8'h2c;
    localparam logic [7:0] CMD_MODE_RD = 8'h2d;
    localparam logic [7:0] CMD_LOCK_SET = 8'ha6;
    localparam logic [7:0] CMD_LOCK_RD = 8'ha7;
    localparam logic [7:0] CMD_SOLID_PGM = 8'he3;
    localparam logic [7:0] CMD_SOLID_ERS = 8'he4;
    localparam logic [7:0] CMD_SOLID_RD = 8'he2;
    localparam logic [7:0] CMD_DYN_WR = 8'he1;
    localparam logic [7:0] CMD_DYN_RD = 8'he0;
    localparam logic [7:0] CMD_GANG_LOCK = 8'h7e;
    localparam logic [7:0] CMD_GANG_UNLOCK = 8'h98;
    localparam logic [7:0] CMD_PASS_UNLOCK = 8'h27;
    localparam logic [7:0] CMD_MASK_WR = 8'h2f;
endpackage

/* rtl/swp_core.sv */
// Per-unit solid and dynamic write-protection logic with a link-side command port.
`timescale 1ns/1ps
// Notes on behaviour
// - A 16-bit one-time mode register; bits 2:1 both one select solid mode.
// - Clearing mode bit 1 fixes solid mode forever.
// - Clearing mode bit 2 fixes password mode forever.
// - A mode write clearing bits 1 and 2 together is aborted.
// - After bit 1 or 2 is cleared, the other bit cannot change.
// - Clearing more than one mode bit sets the program-fail flag.
// - Lock flag is bit 0 of an 8-bit register; upper bits read zero.
// - In solid mode the lock flag resets to one.
// - In password mode the lock flag resets to zero; correct password sets it. Reset reloads mode FFFFh, so the lock flag always resets to one.
// - Lock-bit set command clears the lock flag.
// - In solid mode nothing but reset returns the lock flag to one.
// - While the lock flag is zero, solid program and erase commands are ignored.
// - One solid and one dynamic bit per unit; solid bits start at zero.
// - A set solid bit blocks program or erase of its unit.
// - Solid program sets one bit; solid erase clears them all.
// - Solid read returns 00h or FFh.
// - Dynamic bits reset to one and then block their unit.
// - A dynamic bit protects regardless; clearing it unprotects only if solid is off.
// - Dynamic write sets or clears one bit; gang commands clear or set all.
// - Dynamic read returns 00h or FFh.
// - Mask bit resets to one; zero masks all solid bits; freely changeable.
// - Per-unit scheme acts only when the protection-select bit is one.
// - Write-protect pin low protects every unit in the per-unit scheme.
module swp_core (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_link_clk,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_op,
    input wire logic [15:0] i_cmd_data,
    input wire logic [9:0] i_cmd_unit,
    input wire logic i_pass_ok,
    input wire logic i_protection_select_bit,
    input wire logic i_wp_n,
    input wire logic i_bp_protect,
    input wire logic i_chk_valid,
    input wire logic [9:0] i_chk_unit,
    output logic o_chk_done,
    output logic o_chk_protected,
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_write_enable_latch,
    output logic o_program_fail
);
    // Link side: capture command words and pass them over by a toggle handshake.
    logic lk_nrst_meta_ff, lk_nrst_ff;
    logic lk_tgl_ff;
    logic [7:0] lk_op_ff;
    logic [15:0] lk_data_ff;
    logic [9:0] lk_unit_ff;
    logic lk_pass_ff;
    always_ff @(posedge i_link_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lk_nrst_meta_ff <= 1'b0;
            lk_nrst_ff <= 1'b0;
        end
        else
        begin
            lk_nrst_meta_ff <= 1'b1;
            lk_nrst_ff <= lk_nrst_meta_ff;
        end
    end
    // The word registers hold still until the next command, so the core reads them
    // only after the toggle has been synchronised; the host must space commands.
    always_ff @(posedge i_link_clk or negedge lk_nrst_ff)
    begin
        if (!lk_nrst_ff)
        begin
            lk_tgl_ff <= 1'b0;
            lk_op_ff <= 8'h00;
            lk_data_ff <= 16'h0000;
            lk_unit_ff <= 10'h000;
            lk_pass_ff <= 1'b0;
        end
        else if (i_cmd_valid)
        begin
            lk_tgl_ff <= ~lk_tgl_ff;
            lk_op_ff <= i_cmd_op;
            lk_data_ff <= i_cmd_data;
            lk_unit_ff <= i_cmd_unit;
            lk_pass_ff <= i_pass_ok;
        end
    end

    // Core side synchronisers.
    logic tgl_meta_ff, tgl_sync_ff, tgl_old_ff;
    logic sel_meta_ff, sel_ff, wp_meta_ff, wp_ff, bp_meta_ff, bp_ff;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_old_ff <= 1'b0;
            sel_meta_ff <= 1'b0;
            sel_ff <= 1'b0;
            wp_meta_ff <= 1'b1;
            wp_ff <= 1'b1;
            bp_meta_ff <= 1'b0;
            bp_ff <= 1'b0;
        end
        else
        begin
            tgl_meta_ff <= lk_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_old_ff <= tgl_sync_ff;
            sel_meta_ff <= i_protection_select_bit;
            sel_ff <= sel_meta_ff;
            wp_meta_ff <= i_wp_n;
            wp_ff <= wp_meta_ff;
            bp_meta_ff <= i_bp_protect;
            bp_ff <= bp_meta_ff;
        end
    end
    wire cmd_evt = tgl_sync_ff ^ tgl_old_ff;

    // State registers.
    logic [15:0] mode_ff;
    logic lock_ff, mask_ff, wel_ff, pfail_ff, init_ff;
    logic [swp_pkg::N_UNITS-1:0] solid_ff, dyn_ff;
    logic rd_valid_ff;
    logic [15:0] rd_data_ff;
    logic chk_done_ff, chk_prot_ff;

    wire is_op_write_enable_cmd = cmd_evt && lk_op_ff == swp_pkg::CMD_WRITE_ENABLE_CMD;
    wire asp_on = sel_ff;
    wire mod_ok = cmd_evt && wel_ff;
    wire asp_mod = mod_ok && asp_on;
    wire pass_mode = ~mode_ff[swp_pkg::MODE_PASS_POS];
    wire solid_fixed = ~mode_ff[swp_pkg::MODE_SOLID_POS];
    wire [15:0] mode_clr = mode_ff & ~lk_data_ff;
    wire [4:0] clr_cnt = 5'($countones(mode_clr));
    wire mode_wr = asp_mod && lk_op_ff == swp_pkg::CMD_MODE_WR;
    wire both_clr = ~lk_data_ff[swp_pkg::MODE_SOLID_POS] & ~lk_data_ff[swp_pkg::MODE_PASS_POS];
    wire other_chg = (solid_fixed && mode_clr[swp_pkg::MODE_PASS_POS])
        || (pass_mode && mode_clr[swp_pkg::MODE_SOLID_POS]);
    wire mode_abort = both_clr || other_chg || clr_cnt > 5'd1;
    wire [15:0] nxt_mode = mode_abort ? mode_ff : (mode_ff & lk_data_ff);
    wire lock_set_cmd = asp_mod && lk_op_ff == swp_pkg::CMD_LOCK_SET;
    wire pass_ulk = asp_mod && lk_op_ff == swp_pkg::CMD_PASS_UNLOCK && pass_mode && lk_pass_ff;
    wire solid_cmd_ok = asp_mod && lock_ff;
    wire u_ok = lk_unit_ff < 10'(swp_pkg::N_UNITS);

    // Password-mode bit capture after reset release decides the lock flag default.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            init_ff <= 1'b1;
            lock_ff <= 1'b0;
        end
        else
        begin
            init_ff <= 1'b0;
            if (init_ff)
                lock_ff <= ~pass_mode;
            else if (lock_set_cmd)
                lock_ff <= 1'b0;
            else if (pass_ulk)
                lock_ff <= 1'b1;
        end
    end

    // Mode register models a one-time cell; reset stands in for its shipped state.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mode_ff <= swp_pkg::MODE_RST;
            pfail_ff <= 1'b0;
            wel_ff <= 1'b0;
            mask_ff <= 1'b1;
        end
        else
        begin
            if (mode_wr)
                mode_ff <= nxt_mode;
            if (mode_wr)
                pfail_ff <= clr_cnt > 5'd1;
            if (is_op_write_enable_cmd)
                wel_ff <= 1'b1;
            else if (cmd_evt)
                wel_ff <= 1'b0;
            if (asp_mod && lk_op_ff == swp_pkg::CMD_MASK_WR)
                mask_ff <= lk_data_ff[0];
        end
    end

    // Protection bit arrays.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            solid_ff <= '0;
            dyn_ff <= '1;
        end
        else
        begin
            if (solid_cmd_ok && lk_op_ff == swp_pkg::CMD_SOLID_ERS)
                solid_ff <= '0;
            else if (solid_cmd_ok && lk_op_ff == swp_pkg::CMD_SOLID_PGM && u_ok)
                solid_ff[lk_unit_ff] <= 1'b1;
            if (asp_mod && lk_op_ff == swp_pkg::CMD_GANG_LOCK)
                dyn_ff <= '1;
            else if (asp_mod && lk_op_ff == swp_pkg::CMD_GANG_UNLOCK)
                dyn_ff <= '0;
            else if (asp_mod && lk_op_ff == swp_pkg::CMD_DYN_WR && u_ok)
                dyn_ff[lk_unit_ff] <= lk_data_ff[0];
        end
    end

    // Read-back.
    wire rd_solid = u_ok && solid_ff[lk_unit_ff];
    wire rd_dyn = u_ok && dyn_ff[lk_unit_ff];
    wire is_rd = cmd_evt && (lk_op_ff == swp_pkg::CMD_MODE_RD || lk_op_ff == swp_pkg::CMD_LOCK_RD
        || lk_op_ff == swp_pkg::CMD_SOLID_RD || lk_op_ff == swp_pkg::CMD_DYN_RD);
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0000;
        if (lk_op_ff == swp_pkg::CMD_MODE_RD)
            rd_mux = mode_ff;
        else if (lk_op_ff == swp_pkg::CMD_LOCK_RD)
            rd_mux = {8'h00, swp_pkg::LOCK_UPPER, lock_ff};
        else if (lk_op_ff == swp_pkg::CMD_SOLID_RD)
            rd_mux = {8'h00, rd_solid ? swp_pkg::BYTE_SET : swp_pkg::BYTE_CLR};
        else if (lk_op_ff == swp_pkg::CMD_DYN_RD)
            rd_mux = {8'h00, rd_dyn ? swp_pkg::BYTE_SET : swp_pkg::BYTE_CLR};
    end

    // Protection check for the array program and erase engine.
    wire chk_ok = i_chk_unit < 10'(swp_pkg::N_UNITS);
    wire unit_prot = chk_ok ? (dyn_ff[i_chk_unit] | (solid_ff[i_chk_unit] & mask_ff)) : 1'b1;
    wire prot_now = asp_on ? (~wp_ff | unit_prot) : bp_ff;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 16'h0000;
            chk_done_ff <= 1'b0;
            chk_prot_ff <= 1'b0;
        end
        else
        begin
            rd_valid_ff <= is_rd;
            if (is_rd)
                rd_data_ff <= rd_mux;
            chk_done_ff <= i_chk_valid;
            if (i_chk_valid)
                chk_prot_ff <= prot_now;
        end
    end
    assign o_rd_valid = rd_valid_ff;
    assign o_rd_data = rd_data_ff;
    assign o_chk_done = chk_done_ff;
    assign o_chk_protected = chk_prot_ff;
    assign o_write_enable_latch = wel_ff;
    assign o_program_fail = pfail_ff;

    // Checks on the mode register.
    mode_abort_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        mode_wr && both_clr |=> $stable(mode_ff))
        else $error("both mode bits cleared");
    mode_fail_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        mode_wr && clr_cnt > 5'd1 |=> pfail_ff)
        else $error("fail flag not set");
    mode_other_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        solid_fixed |=> !$fell(mode_ff[swp_pkg::MODE_PASS_POS]))
        else $error("other bit changed");
    mode_pass_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        pass_mode |=> $stable(mode_ff[swp_pkg::MODE_SOLID_POS]))
        else $error("solid bit changed in password mode");
    mode_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        mode_wr |=> (mode_ff & ~$past(mode_ff)) == 16'h0000)
        else $error("mode bit set back to one");

    // Checks on the lock flag and the write enable latch.
    lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !init_ff && !pass_mode && !lock_ff |=> !lock_ff)
        else $error("lock flag reopened");
    lock_init_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        init_ff |=> lock_ff != $past(pass_mode))
        else $error("lock flag default wrong");
    lock_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        lock_set_cmd && !init_ff |=> !lock_ff)
        else $error("lock flag not cleared");
    lock_open_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        pass_ulk && !init_ff |=> lock_ff)
        else $error("password unlock ignored");
    wel_need_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !wel_ff |=> $stable(dyn_ff) && $stable(mode_ff))
        else $error("write without enable");
    wel_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        is_op_write_enable_cmd |=> wel_ff)
        else $error("write enable not latched");

    // Checks on the bit arrays.
    solid_frozen_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !lock_ff && !init_ff |=> $stable(solid_ff))
        else $error("solid bits changed");
    solid_pgm_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        solid_cmd_ok && lk_op_ff == swp_pkg::CMD_SOLID_PGM && u_ok |=> solid_ff[$past(lk_unit_ff)])
        else $error("solid bit not programmed");
    solid_grow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !(solid_cmd_ok && lk_op_ff == swp_pkg::CMD_SOLID_ERS)
        |=> (solid_ff & $past(solid_ff)) == $past(solid_ff))
        else $error("solid bit cleared singly");
    solid_ers_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        solid_cmd_ok && lk_op_ff == swp_pkg::CMD_SOLID_ERS |=> solid_ff == '0)
        else $error("solid erase incomplete");
    gang_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        asp_mod && lk_op_ff == swp_pkg::CMD_GANG_UNLOCK |=> dyn_ff == '0)
        else $error("gang");
    gang_lock_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        asp_mod && lk_op_ff == swp_pkg::CMD_GANG_LOCK |=> dyn_ff == '1)
        else $error("gang lock");
    dyn_wr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        asp_mod && lk_op_ff == swp_pkg::CMD_DYN_WR && u_ok
        |=> dyn_ff[$past(lk_unit_ff)] == $past(lk_data_ff[0]))
        else $error("dynamic bit write lost");
    mask_wr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        asp_mod && lk_op_ff == swp_pkg::CMD_MASK_WR |=> mask_ff == $past(lk_data_ff[0]))
        else $error("mask bit write lost");
    sel_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !asp_on |=> $stable(dyn_ff) && $stable(solid_ff))
        else $error("bits changed with scheme off");

    // Checks on the protection answer; in the per-unit scheme the pin wins over every bit.
    prot_wp_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chk_valid && asp_on && !wp_ff |=> chk_done_ff && chk_prot_ff)
        else $error("wp missed");
    prot_dyn_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chk_valid && asp_on && chk_ok && dyn_ff[i_chk_unit] |=> chk_prot_ff)
        else $error("dynamic bit ignored");
    prot_solid_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chk_valid && asp_on && chk_ok && solid_ff[i_chk_unit] && mask_ff |=> chk_prot_ff)
        else $error("solid bit ignored");
    prot_free_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chk_valid && asp_on && wp_ff && chk_ok && !dyn_ff[i_chk_unit]
        && !(solid_ff[i_chk_unit] && mask_ff) |=> !chk_prot_ff)
        else $error("free unit protected");
    prot_bp_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_chk_valid && !asp_on |=> chk_prot_ff == $past(bp_ff))
        else $error("block-protect answer wrong");

    // Checks on the read-back encodings.
    rd_lock_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rd_valid && lk_op_ff == swp_pkg::CMD_LOCK_RD |-> o_rd_data[15:1] == 15'h0000)
        else $error("upper lock bits not zero");
    rd_solid_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rd_valid && lk_op_ff == swp_pkg::CMD_SOLID_RD
        |-> o_rd_data == ($past(rd_solid) ? 16'h00ff : 16'h0000))
        else $error("solid read code wrong");
    rd_dyn_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_rd_valid && lk_op_ff == swp_pkg::CMD_DYN_RD
        |-> o_rd_data == ($past(rd_dyn) ? 16'h00ff : 16'h0000))
        else $error("dynamic read code wrong");

    cov_mode_c: cover property (@(posedge i_clk) disable iff (!i_nrst) mode_wr && !mode_abort);
    cov_lock_c: cover property (@(posedge i_clk) disable iff (!i_nrst) lock_set_cmd);
    cov_prot_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_chk_done && !o_chk_protected);
    cov_pass_c: cover property (@(posedge i_clk) disable iff (!i_nrst) pass_ulk);
    cov_wp_c: cover property (@(posedge i_clk) disable iff (!i_nrst) chk_done_ff && !wp_ff);
endmodule

/* bench/swp_host.sv */
// Host controller model that issues protection commands on the link clock.
`timescale 1ns/1ps
module swp_host (
    input wire logic i_link_clk,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_op,
    output logic [15:0] o_cmd_data,
    output logic [9:0] o_cmd_unit
);
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd_op = 8'h00;
        o_cmd_data = 16'h0000;
        o_cmd_unit = 10'h000;
    end
    // Idle lines show the inverse of the last command, so sampling them outside a command shows.
    task automatic send(input logic [7:0] op, input logic [15:0] d, input logic [8:0] u);
        @(posedge i_link_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_op <= op;
        o_cmd_data <= d;
        o_cmd_unit <= {1'b0, u};
        @(posedge i_link_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_op <= ~op;
        o_cmd_data <= ~d;
        o_cmd_unit <= ~{1'b0, u};
        repeat (6) @(posedge i_link_clk);
    endtask
    task automatic send_mod(input logic [7:0] op, input logic [15:0] d, input logic [8:0] u);
        send(swp_pkg::CMD_WRITE_ENABLE_CMD, 16'h0, 9'h0);
        send(op, d, u);
    endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the sector write-protection core.
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] B = 16'h00ff;
    logic i_clk, i_link_clk, i_nrst, cmd_valid, pass_ok, sel, wp_n, bp, chk_valid;
    logic chk_done, chk_prot, rd_valid, write_enable_latch, pfail;
    logic [7:0] cmd_op;
    logic [15:0] cmd_data, rd_data, rd_last;
    logic [9:0] cmd_unit, chk_unit;
    int failures, check_count;
    swp_host swp_host_i (.i_link_clk(i_link_clk), .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op),
        .o_cmd_data(cmd_data), .o_cmd_unit(cmd_unit));
    swp_core swp_core_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_link_clk(i_link_clk),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_data(cmd_data),
        .i_cmd_unit(cmd_unit), .i_pass_ok(pass_ok), .i_protection_select_bit(sel),
        .i_wp_n(wp_n), .i_bp_protect(bp), .i_chk_valid(chk_valid), .i_chk_unit(chk_unit),
        .o_chk_done(chk_done), .o_chk_protected(chk_prot), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_write_enable_latch(write_enable_latch), .o_program_fail(pfail));
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial
    begin
        i_link_clk = 1'b0;
        #7;
        forever #32 i_link_clk = ~i_link_clk;
    end
    always @(posedge i_clk)
    begin
        if (rd_valid === 1'b1)
            rd_last <= rd_data;
    end
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The stale value is wiped first, so a read that never answers cannot pass.
    task automatic rd(input logic [7:0] op, input logic [8:0] u, input logic [15:0] m,
        input logic [15:0] exp);
        rd_last = 16'hxxxx;
        swp_host_i.send(op, 16'h0, u);
        check(rd_last & m, exp);
    endtask
    task automatic chk(input logic [8:0] u, input logic exp);
        @(posedge i_clk);
        chk_valid <= 1'b1;
        chk_unit <= {1'b0, u};
        @(posedge i_clk);
        chk_valid <= 1'b0;
        #1;
        check({14'h0, chk_done, chk_prot}, {14'h0, 1'b1, exp});
    endtask
    task automatic lv(input logic s, input logic w, input logic b, input logic ok);
        @(posedge i_clk);
        sel <= s;
        wp_n <= w;
        bp <= b;
        pass_ok <= ok;
        repeat (5) @(posedge i_clk);
    endtask
    task automatic reset_dut;
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
    initial
    begin
        #200us;
        failures++;
        report_and_stop();
    end
    initial
    begin
        failures = 0;
        check_count = 0;
        i_nrst = 1'b0;
        pass_ok = 1'b0;
        sel = 1'b1;
        wp_n = 1'b1;
        bp = 1'b0;
        chk_valid = 1'b0;
        chk_unit = 10'h000;
        reset_dut();
        rd(swp_pkg::CMD_MODE_RD, 9'h0, 16'hffff, 16'hffff);
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0001);
        rd(swp_pkg::CMD_SOLID_RD, 9'h5, B, 16'h0000);
        rd(swp_pkg::CMD_DYN_RD, 9'h5, B, 16'h00ff);
        chk(9'h5, 1'b1);
        swp_host_i.send(swp_pkg::CMD_SOLID_PGM, 16'h0, 9'h9);
        rd(swp_pkg::CMD_SOLID_RD, 9'h9, B, 16'h0000);
        swp_host_i.send_mod(swp_pkg::CMD_GANG_UNLOCK, 16'h0, 9'h0);
        chk(9'h5, 1'b0);
        swp_host_i.send_mod(swp_pkg::CMD_SOLID_PGM, 16'h0, 9'h5);
        rd(swp_pkg::CMD_SOLID_RD, 9'h5, B, 16'h00ff);
        rd(swp_pkg::CMD_SOLID_RD, 9'h4, B, 16'h0000);
        chk(9'h5, 1'b1);
        swp_host_i.send_mod(swp_pkg::CMD_MASK_WR, 16'h0, 9'h0);
        chk(9'h5, 1'b0);
        swp_host_i.send_mod(swp_pkg::CMD_MASK_WR, 16'h1, 9'h0);
        chk(9'h5, 1'b1);
        swp_host_i.send_mod(swp_pkg::CMD_DYN_WR, 16'h1, 9'h7);
        rd(swp_pkg::CMD_DYN_RD, 9'h7, B, 16'h00ff);
        chk(9'h7, 1'b1);
        swp_host_i.send_mod(swp_pkg::CMD_GANG_LOCK, 16'h0, 9'h0);
        chk(9'h9, 1'b1);
        swp_host_i.send_mod(swp_pkg::CMD_GANG_UNLOCK, 16'h0, 9'h0);
        lv(1'b1, 1'b0, 1'b0, 1'b0);
        chk(9'h9, 1'b1);
        lv(1'b0, 1'b1, 1'b0, 1'b0);
        swp_host_i.send_mod(swp_pkg::CMD_GANG_LOCK, 16'h0, 9'h0);
        chk(9'h9, 1'b0);
        lv(1'b0, 1'b1, 1'b1, 1'b0);
        chk(9'h9, 1'b1);
        lv(1'b1, 1'b1, 1'b0, 1'b1);
        chk(9'h9, 1'b0);
        swp_host_i.send_mod(swp_pkg::CMD_LOCK_SET, 16'h0, 9'h0);
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0000);
        swp_host_i.send_mod(swp_pkg::CMD_PASS_UNLOCK, 16'h0, 9'h0);
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0000);
        swp_host_i.send_mod(swp_pkg::CMD_SOLID_ERS, 16'h0, 9'h0);
        rd(swp_pkg::CMD_SOLID_RD, 9'h5, B, 16'h00ff);
        reset_dut();
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0001);
        swp_host_i.send_mod(swp_pkg::CMD_MODE_WR, 16'hfff9, 9'h0);
        rd(swp_pkg::CMD_MODE_RD, 9'h0, 16'hffff, 16'hffff);
        check({15'h0, pfail}, 16'h0001);
        swp_host_i.send_mod(swp_pkg::CMD_MODE_WR, 16'hfffd, 9'h0);
        rd(swp_pkg::CMD_MODE_RD, 9'h0, 16'hffff, 16'hfffd);
        swp_host_i.send_mod(swp_pkg::CMD_MODE_WR, 16'hfff9, 9'h0);
        rd(swp_pkg::CMD_MODE_RD, 9'h0, 16'hffff, 16'hfffd);
        reset_dut();
        swp_host_i.send_mod(swp_pkg::CMD_MODE_WR, 16'hfffb, 9'h0);
        rd(swp_pkg::CMD_MODE_RD, 9'h0, 16'hffff, 16'hfffb);
        swp_host_i.send_mod(swp_pkg::CMD_LOCK_SET, 16'h0, 9'h0);
        lv(1'b1, 1'b1, 1'b0, 1'b0);
        swp_host_i.send_mod(swp_pkg::CMD_PASS_UNLOCK, 16'h0, 9'h0);
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0000);
        lv(1'b1, 1'b1, 1'b0, 1'b1);
        swp_host_i.send_mod(swp_pkg::CMD_PASS_UNLOCK, 16'h0, 9'h0);
        rd(swp_pkg::CMD_LOCK_RD, 9'h0, B, 16'h0001);
        swp_host_i.send_mod(swp_pkg::CMD_DYN_WR, 16'h0, 9'h1f0);
        rd(swp_pkg::CMD_DYN_RD, 9'h1f0, B, 16'h0000);
        chk(9'h1f0, 1'b0);
        report_and_stop();
    end
endmodule
